/* logic/dsl_pkg.sv */
// constants and shared types for the drive status lamp driver
// assumes a 200 MHz drive clock and a synchronous active-low reset
// Operation
// R1: stopped, not ready, idle: lamp off regardless of polarity select.
// R2: stopped, not ready, command executing: lamp on regardless of polarity.
// R3: ready and idle: lamp lit when select is 0, dark when 1.
// R4: ready and executing: lamp dark when select is 0, lit when 1.
// R5: one configuration bit chooses between the two ready-state lamp schemes.
// R6: during ready transitions blink 0.5 s lit, 0.5 s dark.
// R7: while format runs, toggle lamp lit and dark, overriding normal mapping.
// R8: output is active-low open collector: pull low to light, release for dark.
// R9: blink and toggle timing from a clock counter, reset to dark phase.
package dsl_pkg;
    localparam int unsigned CLOCK_HZ = 200_000_000;
    localparam int unsigned BLINK_HALF_MS = 500; // 0.5 s each phase
    localparam int unsigned BLINK_HALF_CYCLES = (CLOCK_HZ / 1000) * BLINK_HALF_MS;
    localparam int unsigned FORMAT_HALF_MS = 500; // format toggle half period
    localparam int unsigned FORMAT_HALF_CYCLES = (CLOCK_HZ / 1000) * FORMAT_HALF_MS;
    localparam int unsigned CNT_W = 27;
    localparam logic PHASE_RESET = 1'b0; // dark phase after reset
    localparam logic LAMP_RESET = 1'b0;

    typedef enum logic [1:0] {
        DSL_MODE_NORMAL = 2'b00,
        DSL_MODE_BLINK = 2'b01,
        DSL_MODE_FORMAT = 2'b11
    } dsl_mode_e;
endpackage

/* logic/dsl_tick_if.sv */
// carries the timebase half-period and phase between lamp modules
// assumes both ends share the drive clock
`timescale 1ns/100ps
interface dsl_tick_if;
    logic [dsl_pkg::CNT_W-1:0] half_cycles;
    logic restart;
    logic phase;
    modport gen (input half_cycles, input restart, output phase);
    modport use_side (output half_cycles, output restart, input phase);
endinterface

/* logic/dsl_phase_gen.sv */
// square-wave phase generator counting drive clock cycles
// assumes half_cycles is at least one and held stable between restarts
`timescale 1ns/100ps
module dsl_phase_gen (
    input wire logic clock,
    input wire logic rst_n,
    dsl_tick_if.gen tick
);
    import dsl_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic phase;
    } dsl_gen_s;

    dsl_gen_s st;
    dsl_gen_s next_st;

    // count a half period, then flip the phase
    always_comb begin
        next_st = st;
        if (tick.restart) begin
            next_st.cnt = '0; // R9
            next_st.phase = PHASE_RESET;
        end else if (st.cnt >= tick.half_cycles - CNT_W'(1)) begin
            next_st.cnt = '0;
            next_st.phase = ~st.phase; // R9
        end else begin
            next_st.cnt = st.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st <= '{cnt: '0, phase: PHASE_RESET}; // R9
        end else begin
            st <= next_st;
        end
    end

    assign tick.phase = st.phase;
endmodule

/* logic/dsl_lamp_top.sv */
// drive status lamp driver: maps drive state to an open-collector lamp
// assumes status inputs may be asynchronous to the drive clock
`timescale 1ns/100ps
module dsl_lamp_top #(
    parameter int unsigned BLINK_CYCLES = dsl_pkg::BLINK_HALF_CYCLES,
    parameter int unsigned FORMAT_CYCLES = dsl_pkg::FORMAT_HALF_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic drive_ready,
    input wire logic cmd_active,
    input wire logic ready_transition,
    input wire logic format_active,
    input wire logic lamp_polarity_select,
    output logic drive_status_lamp_o,
    output logic drive_status_lamp_oe
);
    import dsl_pkg::*;

    typedef struct packed {
        logic [4:0] sync1;
        logic [4:0] sync2;
        dsl_mode_e mode;
        logic lit;
        logic oe;
    } dsl_top_s;

    dsl_top_s st;
    dsl_top_s next_st;
    dsl_tick_if tick ();
    logic rdy;
    logic act;
    logic trans;
    logic fmt;
    logic pol;
    logic normal_lit;

    dsl_phase_gen u_gen (
        .clock(clock),
        .rst_n(rst_n),
        .tick(tick)
    );

    assign rdy = st.sync2[0];
    assign act = st.sync2[1];
    assign trans = st.sync2[2];
    assign fmt = st.sync2[3];
    assign pol = st.sync2[4]; // R5

    // ready-state truth table; polarity only matters once ready
    always_comb begin
        if (!rdy) begin
            normal_lit = act; // R1 R2
        end else begin
            normal_lit = act ? pol : ~pol; // R3 R4
        end
    end

    // format beats transition beats normal; restart timebase on mode change
    always_comb begin
        next_st = st;
        next_st.sync1 = {lamp_polarity_select, format_active, ready_transition,
                         cmd_active, drive_ready};
        next_st.sync2 = st.sync1;
        if (fmt) begin
            next_st.mode = DSL_MODE_FORMAT; // R7
        end else if (trans) begin
            next_st.mode = DSL_MODE_BLINK; // R6
        end else begin
            next_st.mode = DSL_MODE_NORMAL;
        end
        case (st.mode)
            DSL_MODE_FORMAT: next_st.lit = tick.phase; // R7
            DSL_MODE_BLINK: next_st.lit = tick.phase; // R6
            DSL_MODE_NORMAL: next_st.lit = normal_lit;
            default: next_st.lit = LAMP_RESET;
        endcase
        next_st.oe = next_st.lit; // R8
    end

    // timebase period follows the selected mode
    always_comb begin
        tick.half_cycles = (next_st.mode == DSL_MODE_FORMAT) ?
            CNT_W'(FORMAT_CYCLES) : CNT_W'(BLINK_CYCLES);
        tick.restart = (next_st.mode != st.mode); // R9
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st <= '{sync1: '0, sync2: '0, mode: DSL_MODE_NORMAL,
                    lit: LAMP_RESET, oe: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // driven level is always low; enable alone sinks the cathode
    assign drive_status_lamp_o = 1'b0; // R8
    assign drive_status_lamp_oe = st.oe;
endmodule

/* test/dsl_lamp_led.sv */
// partner: pull-up resistor and led hanging on the lamp pin
// assumes the output value and enable pair of the driver top
`timescale 1ns/100ps
module dsl_lamp_led (
    input wire logic pin_o,
    input wire logic pin_oe,
    output logic pad,
    output logic lit
);
    // a released pin floats up through the led, never holds its last value
    assign pad = pin_oe ? pin_o : 1'h1;
    assign lit = (pad === 1'h0);
endmodule

/* test/dsl_lamp_monitor.sv */
// port assertions for the lamp driver
// assumes half periods of at least six cycles in simulation
`timescale 1ns/100ps
module dsl_lamp_monitor (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic drive_ready,
    input wire logic cmd_active,
    input wire logic ready_transition,
    input wire logic format_active,
    input wire logic lamp_polarity_select,
    input wire logic drive_status_lamp_o,
    input wire logic drive_status_lamp_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // six stable cycles cover the sync stages and the mode register
    wire oe = drive_status_lamp_oe;
    wire n = !format_active && !ready_transition;
    wire bl = ready_transition && !format_active;
    a_off_idle: assert property ((n && !drive_ready && !cmd_active)[*6] |-> !oe)
        else $error("lamp lit while stopped and idle");
    a_on_busy: assert property ((n && !drive_ready && cmd_active)[*6] |-> oe)
        else $error("lamp dark while stopped and busy");
    a_ready_idle: assert property ((n && drive_ready && !cmd_active &&
        $stable(lamp_polarity_select))[*6] |-> oe == !lamp_polarity_select)
        else $error("ready idle lamp wrong");
    a_ready_busy: assert property ((n && drive_ready && cmd_active &&
        $stable(lamp_polarity_select))[*6] |-> oe == lamp_polarity_select)
        else $error("ready busy lamp wrong");
    a_pin_low: assert property (drive_status_lamp_o == 1'h0)
        else $error("lamp pin driven high");
    a_blink_lit: assert property ((bl[*6] ##0 $rose(oe)) |-> oe[*5])
        else $error("blink lit phase too short");
    a_blink_dark: assert property ((bl[*6] ##0 $fell(oe)) |-> !oe[*5])
        else $error("blink dark phase too short");
    a_fmt_hold: assert property ((format_active[*6] ##0 $changed(oe)) |=> $stable(oe)[*4])
        else $error("format toggle too fast");
    a_fmt_moves: assert property (format_active[*6] |-> ##[1:20] $changed(oe))
        else $error("format toggle stuck");
    a_reset_dark: assert property (disable iff (1'b0) !rst_n |=> !oe)
        else $error("lamp lit after reset");
endmodule

/* test/dsl_lamp_top_tb.sv */
// bench: random normal states, blink, format over blink, mid-run reset
// assumes the led model and monitor are compiled first
`timescale 1ns/100ps
module dsl_lamp_top_tb;
    localparam int unsigned BL = 8;
    localparam int unsigned FM = 6;
    logic clock = 0, rst_n = 0, rdy = 0, cmd = 0, rt = 0, fa = 0, sel = 0;
    logic lamp_o, lamp_oe, pad, lit;
    logic [31:0] got;
    logic [31:0] q[$];
    logic [7:0] lf = 8'h2B;
    int n_errors = 0, n_checks = 0, len;
    event chk;
    always #2.5 clock = ~clock;
    dsl_lamp_top #(.BLINK_CYCLES(BL), .FORMAT_CYCLES(FM)) dsl_lamp_top_inst (.clock(clock),
        .rst_n(rst_n), .drive_ready(rdy), .cmd_active(cmd), .ready_transition(rt),
        .format_active(fa), .lamp_polarity_select(sel), .drive_status_lamp_o(lamp_o),
        .drive_status_lamp_oe(lamp_oe));
    dsl_lamp_led dsl_lamp_led_inst (.pin_o(lamp_o), .pin_oe(lamp_oe), .pad(pad), .lit(lit));
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic results();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // inputs always move one ns after the rising edge
    task automatic step(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic note(input logic [31:0] e, input logic [31:0] g);
        q.push_back(e);
        got = g;
        ->chk;
        // yield so the scoreboard takes this note before any closing report
        #0;
    endtask
    // wait for the lamp to reach v, then count how long it stays there
    task automatic run(input logic v, output int k);
        int w;
        w = 0;
        while (lit !== v && w < 60) begin
            step(1);
            w++;
        end
        k = 0;
        while (lit === v && k < 60) begin
            step(1);
            k++;
        end
        if (w >= 60 || k >= 60) begin
            n_errors++;
            results();
        end
    endtask
    // scoreboard side: oldest note against the latest result
    always @(chk) begin
        n_checks++;
        if (got !== q[0]) begin
            n_errors++;
            $display("BAD t=%0t exp %h got %h", $time, q[0], got);
        end
        void'(q.pop_front());
    end
    initial begin
        step(4);
        rst_n = 1;
        repeat (24) begin
            lf = lfsr(lf);
            {rdy, cmd, sel} = lf[2:0];
            step(8);
            note(rdy ? (cmd ? sel : !sel) : cmd, lit);
        end
        $display("normal test done");
        {rdy, cmd, sel, rt} = 4'h1;
        run(1, len);
        note(BL, len);
        run(0, len);
        note(BL, len);
        rt = 0;
        $display("blink test done");
        step(8);
        {rt, fa, rdy, sel} = 4'hF;
        run(1, len);
        note(FM, len);
        run(0, len);
        note(FM, len);
        rst_n = 0;
        step(2);
        note(0, lit);
        rst_n = 1;
        {rt, fa, sel} = 3'h0;
        step(8);
        note(1, lit);
        $display("format and reset test done");
        results();
    end
endmodule
bind dsl_lamp_top dsl_lamp_monitor dsl_lamp_monitor_inst (.*);
